//--- rtl/pdpsc_consts.svh
// constants for the powerdown pin state controller
`ifndef PDPSC_CONSTS_SVH
`define PDPSC_CONSTS_SVH

// register byte offsets
`define PDPSC_ADDR_CTRL      8'h00
`define PDPSC_ADDR_SERIAL_PORT     8'h04
`define PDPSC_ADDR_FLAGS     8'h08
`define PDPSC_ADDR_STATE     8'h0C
`define PDPSC_ADDR_INT_STAT  8'h10
`define PDPSC_ADDR_INT_MASK  8'h14

// control register fields
`define PDPSC_CTRL_FORCE     0
`define PDPSC_CTRL_XDIS      1
`define PDPSC_CTRL_W         2
`define PDPSC_CTRL_RST       2'h0

// serial configuration register
`define PDPSC_SERIAL_PORT_W        12
`define PDPSC_SERIAL_PORT_RST      12'h000

// held flag outputs
`define PDPSC_FLAGS_W        3
`define PDPSC_FLAGS_RST      3'h0

// interrupt status bits
`define PDPSC_INT_W          6
`define PDPSC_INT_EXTERNAL_INTERRUPT2       0
`define PDPSC_INT_EDGE       1
`define PDPSC_INT_LVL0       2
`define PDPSC_INT_LVL1       3
`define PDPSC_INT_BUSREQ     4
`define PDPSC_INT_PDENTRY    5
`define PDPSC_INT_RST        6'h00

// synchronised pin vector layout
`define PDPSC_SYN_W          18
`define PDPSC_SYN_BR         0
`define PDPSC_SYN_EXTERNAL_INTERRUPT2       1
`define PDPSC_SYN_EDGE       2
`define PDPSC_SYN_LVL0       3
`define PDPSC_SYN_LVL1       4
`define PDPSC_SYN_PWD        5
`define PDPSC_SYN_HSEL       6
`define PDPSC_SYN_HRD        7
`define PDPSC_SYN_HWR        8
`define PDPSC_SYN_HAL        9
`define PDPSC_SYN_SCLK       10
`define PDPSC_SYN_TFS        12
`define PDPSC_SYN_RFS        14
`define PDPSC_SYN_DR         16
`define PDPSC_SYN_RST        18'h001FF

`define PDPSC_ADDR_W         14
`define PDPSC_DATA_W         24
`define PDPSC_HAD_W          16

`endif

//--- rtl/pdpsc_pkg.sv
// types for the powerdown pin state controller
`default_nettype none
package pdpsc_pkg;

  typedef struct packed {
    logic s1_run;
    logic s1_alt;
    logic s1_int_rfs;
    logic s1_int_tfs;
    logic s1_int_sclk;
    logic s1_en;
    logic s0_run;
    logic s0_int_rfs;
    logic s0_mc;
    logic s0_int_tfs;
    logic s0_int_sclk;
    logic s0_en;
  } pdpsc_serial_port_type;

  typedef struct packed {
    logic program_mem_select;
    logic data_mem_select;
    logic byte_mem_select;
    logic io_space_select;
    logic combined_mem_select;
    logic mem_read;
    logic mem_store;
  } pdpsc_strobe_type;

  typedef enum logic [1:0] {
    PDPSC_RUN,
    PDPSC_DOWN
  } pdpsc_mode_type;

endpackage
`default_nettype wire

//--- rtl/pdpsc_ctrl.sv
// pin state control for normal operation and powerdown
//
// Functional notes
// RULE_01 - interrupts latched in powerdown, serviced only after
// RULE_02 - bus request sampled, no grant until wake-up
// RULE_03 - grant parked high unless already granted
// RULE_04 - clock buffer off, oscillator follows disable bit
// RULE_05 - crystal pin high if disabled, else inverted clock
// RULE_06 - clock out and acknowledge held high
// RULE_07 - strobes high, released when bus granted
// RULE_08 - address and data float, data input ignored
// RULE_09 - internal serial clocks static, external ones float
// RULE_10 - serial0 transmit frame driven if enabled internal/multichannel
// RULE_11 - serial0 receive frame driven if enabled internal
// RULE_12 - serial0 frame and data inputs live when enabled
// RULE_13 - transmit data driven only while port operates
// RULE_14 - serial1 inputs live if enabled or alternate
// RULE_15 - serial1 frames driven if enabled with internal framing
// RULE_16 - serial1 transmit data driven if enabled or alternate; code drives it only when enabled and running, or alternate
// RULE_17 - held flag outputs keep their value
// RULE_18 - host strobes honoured only while host selected
// RULE_19 - host bus driven only during host operation
`include "pdpsc_consts.svh"
`default_nettype none
module pdpsc_ctrl
  import pdpsc_pkg::*;
(
  input  wire logic                      CLK,
  input  wire logic                      RSTN,
  // register port
  input  wire logic [7:0]                REG_ADDR,
  input  wire logic [31:0]               REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic [31:0]                    REG_RDATA,
  output logic                           IRQ,
  // powerdown and clocking
  input  wire logic                      POWERDOWN_REQ_N,
  output logic                           POWERDOWN_ACK,
  input  wire logic                      CLOCK_INPUT_PIN,
  output logic                           CLOCK_BUFFER_EN,
  output logic                           OSCILLATOR_EN,
  output logic                           CRYSTAL_OUT,
  output logic                           PROCESSOR_CLOCK_OUT,
  // interrupt pins
  input  wire logic                      EXTERNAL_INTERRUPT2_N,
  input  wire logic                      EDGE_INTERRUPT_REQ_N,
  input  wire logic                      LEVEL_INTERRUPT_REQ0_N,
  input  wire logic                      LEVEL_INTERRUPT_REQ1_N,
  // bus arbitration
  input  wire logic                      BUS_REQUEST_N,
  output logic                           BUS_GRANT_N,
  // external memory bus, core side then pin side
  input  wire pdpsc_strobe_type          CORE_STROBE_N,
  input  wire logic [`PDPSC_ADDR_W-1:0]  CORE_ADDR,
  input  wire logic [`PDPSC_DATA_W-1:0]  CORE_DATA_OUT,
  input  wire logic                      CORE_DATA_DRIVE,
  output logic [`PDPSC_DATA_W-1:0]       CORE_DATA_IN,
  output pdpsc_strobe_type               STROBE_N_O,
  output logic                           STROBE_OE,
  output logic [`PDPSC_ADDR_W-1:0]       ADDR_O,
  output logic                           ADDR_OE,
  input  wire logic [`PDPSC_DATA_W-1:0]  DATA_I,
  output logic [`PDPSC_DATA_W-1:0]       DATA_O,
  output logic                           DATA_OE,
  // serial ports, index 0 and 1
  input  wire logic [1:0]                CORE_SCLK,
  input  wire logic [1:0]                CORE_TX_FRAME,
  input  wire logic [1:0]                CORE_RX_FRAME,
  input  wire logic [1:0]                CORE_TX_DATA,
  input  wire logic [1:0]                SERIAL_CLOCK_I,
  output logic [1:0]                     SERIAL_CLOCK_O,
  output logic [1:0]                     SERIAL_CLOCK_OE,
  input  wire logic [1:0]                SERIAL_TX_FRAME_I,
  output logic [1:0]                     SERIAL_TX_FRAME_O,
  output logic [1:0]                     SERIAL_TX_FRAME_OE,
  input  wire logic [1:0]                SERIAL_RX_FRAME_I,
  output logic [1:0]                     SERIAL_RX_FRAME_O,
  output logic [1:0]                     SERIAL_RX_FRAME_OE,
  input  wire logic [1:0]                SERIAL_RX_DATA_I,
  output logic [1:0]                     SERIAL_TX_DATA_O,
  output logic [1:0]                     SERIAL_TX_DATA_OE,
  output logic [1:0]                     SERIAL_CLOCK_CORE,
  output logic [1:0]                     SERIAL_TX_FRAME_CORE,
  output logic [1:0]                     SERIAL_RX_FRAME_CORE,
  output logic [1:0]                     SERIAL_RX_DATA_CORE,
  // general flag outputs
  output logic [`PDPSC_FLAGS_W-1:0]      HELD_OUTPUT_BITS,
  // host port
  input  wire logic                      HOST_PORT_SELECT_N,
  input  wire logic                      HOST_READ_STROBE_N,
  input  wire logic                      HOST_STORE_STROBE_N,
  input  wire logic                      HOST_ADDRESS_LATCH,
  input  wire logic [`PDPSC_HAD_W-1:0]   CORE_HOST_RDATA,
  input  wire logic                      CORE_HOST_ACK,
  output logic                           HOST_READ_CORE,
  output logic                           HOST_STORE_CORE,
  output logic                           HOST_LATCH_CORE,
  output logic [`PDPSC_HAD_W-1:0]        HOST_ADDR_DATA_O,
  output logic                           HOST_ADDR_DATA_OE,
  output logic                           HOST_ACCESS_ACK_N
);

  logic [`PDPSC_SYN_W-1:0]   syn1_q, syn2_q, syn3_q, pin_q;
  logic [`PDPSC_SYN_W-1:0]   pin_raw;
  logic [`PDPSC_CTRL_W-1:0]  ctrl_q;
  pdpsc_serial_port_type           serial_port_q;
  logic [`PDPSC_FLAGS_W-1:0] flags_q;
  logic [`PDPSC_INT_W-1:0]   int_stat_q, int_mask_q, int_set;
  pdpsc_mode_type            mode_q;
  logic                      pd, pd_entry, edge_prev_q, grant_q, clk_div_q;
  logic [1:0]                sclk_hold_q;
  logic [31:0]               rdata_d;

  // three-stage synchronisers for the control, host and serial input pins
  assign pin_raw = {SERIAL_RX_DATA_I, SERIAL_RX_FRAME_I, SERIAL_TX_FRAME_I, SERIAL_CLOCK_I,
                    HOST_ADDRESS_LATCH, HOST_STORE_STROBE_N, HOST_READ_STROBE_N,
                    HOST_PORT_SELECT_N, POWERDOWN_REQ_N, LEVEL_INTERRUPT_REQ1_N,
                    LEVEL_INTERRUPT_REQ0_N, EDGE_INTERRUPT_REQ_N, EXTERNAL_INTERRUPT2_N,
                    BUS_REQUEST_N};

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      syn1_q <= `PDPSC_SYN_RST;
      syn2_q <= `PDPSC_SYN_RST;
      syn3_q <= `PDPSC_SYN_RST;
    end else begin
      syn1_q <= pin_raw;
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_q <= `PDPSC_SYN_RST;
    end else begin
      pin_q <= (syn2_q & ~(syn2_q ^ syn3_q)) | (pin_q & (syn2_q ^ syn3_q));
    end
  end

  // powerdown state
  assign pd       = (mode_q == PDPSC_DOWN);
  assign pd_entry = !pd && (!pin_q[`PDPSC_SYN_PWD] || ctrl_q[`PDPSC_CTRL_FORCE]);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= PDPSC_RUN;
    end else begin
      case (mode_q)
        PDPSC_RUN: begin
          if (pd_entry) begin
            mode_q <= PDPSC_DOWN;
          end
        end
        PDPSC_DOWN: begin
          if (pin_q[`PDPSC_SYN_PWD] && !ctrl_q[`PDPSC_CTRL_FORCE]) begin
            mode_q <= PDPSC_RUN;
          end
        end
        default: begin
          mode_q <= PDPSC_RUN;
        end
      endcase
    end
  end

  // bus grant follows request only while running
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      grant_q <= 1'b0;
    end else if (!pd) begin
      grant_q <= !pin_q[`PDPSC_SYN_BR];
    end
  end
  assign BUS_GRANT_N = !grant_q; // RULE_02 RULE_03

  // clocking
  assign CLOCK_BUFFER_EN = !pd; // RULE_04
  assign OSCILLATOR_EN   = !(pd && ctrl_q[`PDPSC_CTRL_XDIS]); // RULE_04
  // straight inversion; sampling would alias the oscillator
  assign CRYSTAL_OUT     = (pd && ctrl_q[`PDPSC_CTRL_XDIS]) ? 1'b1 : !CLOCK_INPUT_PIN; // RULE_05

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_div_q <= 1'b1;
    end else if (pd || pd_entry) begin
      clk_div_q <= 1'b1; // RULE_06
    end else begin
      clk_div_q <= !clk_div_q;
    end
  end
  assign PROCESSOR_CLOCK_OUT = clk_div_q;
  assign POWERDOWN_ACK       = pd; // RULE_06

  // external memory bus
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      STROBE_N_O <= '1;
      ADDR_O     <= '0;
      DATA_O     <= '0;
    end else if (pd || pd_entry) begin
      STROBE_N_O <= '1; // RULE_07
    end else begin
      STROBE_N_O <= CORE_STROBE_N;
      ADDR_O     <= CORE_ADDR;
      DATA_O     <= CORE_DATA_OUT;
    end
  end
  assign STROBE_OE = !grant_q; // RULE_07
  assign ADDR_OE   = !pd && !grant_q; // RULE_08
  assign DATA_OE   = !pd && !grant_q && CORE_DATA_DRIVE; // RULE_08

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CORE_DATA_IN <= '0;
    end else if (!pd) begin
      CORE_DATA_IN <= DATA_I; // RULE_08
    end
  end

  // serial clocks: internal ones freeze in powerdown
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_hold_q <= '0;
    end else if (!pd) begin
      sclk_hold_q <= CORE_SCLK;
    end
  end
  assign SERIAL_CLOCK_O     = pd ? sclk_hold_q : CORE_SCLK; // RULE_09
  assign SERIAL_CLOCK_OE    = {serial_port_q.s1_int_sclk, serial_port_q.s0_int_sclk}; // RULE_09
  assign SERIAL_CLOCK_CORE  = pin_q[`PDPSC_SYN_SCLK +: 2]; // RULE_09

  assign SERIAL_TX_FRAME_O  = CORE_TX_FRAME;
  assign SERIAL_RX_FRAME_O  = CORE_RX_FRAME;
  assign SERIAL_TX_DATA_O   = CORE_TX_DATA;
  assign SERIAL_TX_FRAME_OE[0] = serial_port_q.s0_en && (serial_port_q.s0_int_tfs || serial_port_q.s0_mc); // RULE_10
  assign SERIAL_RX_FRAME_OE[0] = serial_port_q.s0_en && serial_port_q.s0_int_rfs; // RULE_11
  assign SERIAL_TX_FRAME_OE[1] = serial_port_q.s1_en && serial_port_q.s1_int_tfs; // RULE_15
  assign SERIAL_RX_FRAME_OE[1] = serial_port_q.s1_en && serial_port_q.s1_int_rfs; // RULE_15
  assign SERIAL_TX_DATA_OE[0]  = serial_port_q.s0_en && serial_port_q.s0_run; // RULE_13
  assign SERIAL_TX_DATA_OE[1]  = (serial_port_q.s1_en && serial_port_q.s1_run) || serial_port_q.s1_alt; // RULE_13 RULE_16

  // unused frame and data inputs are held inactive
  assign SERIAL_TX_FRAME_CORE[0] = serial_port_q.s0_en && pin_q[`PDPSC_SYN_TFS]; // RULE_12
  assign SERIAL_RX_FRAME_CORE[0] = serial_port_q.s0_en && pin_q[`PDPSC_SYN_RFS]; // RULE_12
  assign SERIAL_RX_DATA_CORE[0]  = serial_port_q.s0_en && pin_q[`PDPSC_SYN_DR]; // RULE_12
  assign SERIAL_TX_FRAME_CORE[1] = (serial_port_q.s1_en || serial_port_q.s1_alt) && pin_q[`PDPSC_SYN_TFS + 1]; // RULE_14
  assign SERIAL_RX_FRAME_CORE[1] = (serial_port_q.s1_en || serial_port_q.s1_alt) && pin_q[`PDPSC_SYN_RFS + 1]; // RULE_14
  assign SERIAL_RX_DATA_CORE[1]  = (serial_port_q.s1_en || serial_port_q.s1_alt) && pin_q[`PDPSC_SYN_DR + 1]; // RULE_14

  // host port
  assign HOST_READ_CORE    = !pin_q[`PDPSC_SYN_HSEL] && !pin_q[`PDPSC_SYN_HRD]; // RULE_18
  assign HOST_STORE_CORE   = !pin_q[`PDPSC_SYN_HSEL] && !pin_q[`PDPSC_SYN_HWR]; // RULE_18
  assign HOST_LATCH_CORE   = !pin_q[`PDPSC_SYN_HSEL] && pin_q[`PDPSC_SYN_HAL]; // RULE_18
  assign HOST_ADDR_DATA_OE = HOST_READ_CORE; // RULE_19
  assign HOST_ACCESS_ACK_N = !(CORE_HOST_ACK && !pd);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HOST_ADDR_DATA_O <= '0;
    end else begin
      HOST_ADDR_DATA_O <= CORE_HOST_RDATA;
    end
  end

  // interrupt events
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      edge_prev_q <= 1'b1;
    end else begin
      edge_prev_q <= pin_q[`PDPSC_SYN_EDGE];
    end
  end

  always_comb begin
    int_set = '0;
    int_set[`PDPSC_INT_EXTERNAL_INTERRUPT2]    = !pin_q[`PDPSC_SYN_EXTERNAL_INTERRUPT2]; // RULE_01
    int_set[`PDPSC_INT_EDGE]    = edge_prev_q && !pin_q[`PDPSC_SYN_EDGE]; // RULE_01
    int_set[`PDPSC_INT_LVL0]    = !pin_q[`PDPSC_SYN_LVL0]; // RULE_01
    int_set[`PDPSC_INT_LVL1]    = !pin_q[`PDPSC_SYN_LVL1]; // RULE_01
    int_set[`PDPSC_INT_BUSREQ]  = pd && !pin_q[`PDPSC_SYN_BR]; // RULE_02
    int_set[`PDPSC_INT_PDENTRY] = pd_entry;
  end

  // set wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_stat_q <= `PDPSC_INT_RST;
    end else if (REG_WR && REG_ADDR == `PDPSC_ADDR_INT_STAT) begin
      int_stat_q <= (int_stat_q & ~REG_WDATA[`PDPSC_INT_W-1:0]) | int_set;
    end else begin
      int_stat_q <= int_stat_q | int_set;
    end
  end

  assign IRQ = !pd && |(int_stat_q & int_mask_q); // RULE_01

  // register writes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q     <= `PDPSC_CTRL_RST;
      serial_port_q    <= `PDPSC_SERIAL_PORT_RST;
      int_mask_q <= `PDPSC_INT_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `PDPSC_ADDR_CTRL:     ctrl_q     <= REG_WDATA[`PDPSC_CTRL_W-1:0];
        `PDPSC_ADDR_SERIAL_PORT:    serial_port_q    <= REG_WDATA[`PDPSC_SERIAL_PORT_W-1:0];
        `PDPSC_ADDR_INT_MASK: int_mask_q <= REG_WDATA[`PDPSC_INT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags_q <= `PDPSC_FLAGS_RST;
    end else if (REG_WR && REG_ADDR == `PDPSC_ADDR_FLAGS && !pd) begin
      flags_q <= REG_WDATA[`PDPSC_FLAGS_W-1:0]; // RULE_17
    end
  end
  assign HELD_OUTPUT_BITS = flags_q; // RULE_17

  // register reads, data one cycle after the strobe
  always_comb begin
    rdata_d = '0;
    case (REG_ADDR)
      `PDPSC_ADDR_CTRL:     rdata_d[`PDPSC_CTRL_W-1:0]  = ctrl_q;
      `PDPSC_ADDR_SERIAL_PORT:    rdata_d[`PDPSC_SERIAL_PORT_W-1:0] = serial_port_q;
      `PDPSC_ADDR_FLAGS:    rdata_d[`PDPSC_FLAGS_W-1:0] = flags_q;
      `PDPSC_ADDR_STATE:    rdata_d[2:0]                = {grant_q, !pin_q[`PDPSC_SYN_BR], pd};
      `PDPSC_ADDR_INT_STAT: rdata_d[`PDPSC_INT_W-1:0]   = int_stat_q;
      `PDPSC_ADDR_INT_MASK: rdata_d[`PDPSC_INT_W-1:0]   = int_mask_q;
      default:              rdata_d = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= REG_RD ? rdata_d : '0;
    end
  end

endmodule
`default_nettype wire

//--- tb/pdpsc_chk.sv
// port assertions for the powerdown pin state controller
`default_nettype none
module pdpsc_chk
  import pdpsc_pkg::*;
(
  input wire logic             CLK,
  input wire logic             RSTN,
  input wire logic             POWERDOWN_REQ_N,
  input wire logic             POWERDOWN_ACK,
  input wire logic             PROCESSOR_CLOCK_OUT,
  input wire logic             CLOCK_BUFFER_EN,
  input wire logic             OSCILLATOR_EN,
  input wire logic             CLOCK_INPUT_PIN,
  input wire logic             CRYSTAL_OUT,
  input wire logic             IRQ,
  input wire logic             BUS_GRANT_N,
  input wire pdpsc_strobe_type STROBE_N_O,
  input wire logic             STROBE_OE,
  input wire logic             ADDR_OE,
  input wire logic             DATA_OE,
  input wire logic [1:0]       SERIAL_CLOCK_O,
  input wire logic [1:0]       SERIAL_CLOCK_OE,
  input wire logic [2:0]       HELD_OUTPUT_BITS,
  input wire logic             HOST_READ_CORE,
  input wire logic             HOST_ADDR_DATA_OE,
  input wire logic             HOST_ACCESS_ACK_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // two cycles in a row powered down
  sequence s_held;
    POWERDOWN_ACK ##1 POWERDOWN_ACK;
  endsequence
  sequence s_req;
    !POWERDOWN_REQ_N [*8];
  endsequence
  AST_ENTRY: assert property (s_req |-> POWERDOWN_ACK and PROCESSOR_CLOCK_OUT)
    else $error("no powerdown after request");
  AST_CLK_OUT_HIGH: assert property (POWERDOWN_ACK |-> PROCESSOR_CLOCK_OUT)
    else $error("clock out low in powerdown");
  AST_CLK_BUFFER_OFF: assert property (POWERDOWN_ACK |-> !CLOCK_BUFFER_EN)
    else $error("clock buffer on in powerdown");
  AST_CRYSTAL_PIN: assert property (POWERDOWN_ACK |-> CRYSTAL_OUT == (OSCILLATOR_EN ? !CLOCK_INPUT_PIN : 1'b1))
    else $error("crystal pin wrong in powerdown");
  AST_GRANT_FROZEN: assert property (s_held |-> $stable(BUS_GRANT_N))
    else $error("grant changed in powerdown");
  AST_STROBES_PARKED: assert property (POWERDOWN_ACK |-> STROBE_OE == BUS_GRANT_N && STROBE_N_O == 7'h7F)
    else $error("strobes not parked");
  AST_BUS_FLOATS: assert property (POWERDOWN_ACK |-> !ADDR_OE && !DATA_OE)
    else $error("address or data driven in powerdown");
  AST_IRQ_HELD: assert property (POWERDOWN_ACK |-> !IRQ)
    else $error("interrupt serviced in powerdown");
  AST_SCLK_STATIC: assert property (s_held ##0 SERIAL_CLOCK_OE[0] |-> $stable(SERIAL_CLOCK_O[0]))
    else $error("internal serial clock moves");
  AST_SERIAL1_CLOCK_STATIC: assert property (s_held ##0 SERIAL_CLOCK_OE[1] |-> $stable(SERIAL_CLOCK_O[1]))
    else $error("internal serial clock one moves");
  AST_FLAGS_HELD: assert property (s_held |-> $stable(HELD_OUTPUT_BITS))
    else $error("flag outputs changed");
  AST_HOST_BUS: assert property (HOST_ADDR_DATA_OE |-> HOST_READ_CORE)
    else $error("host bus driven without read");
  AST_HOST_ACK: assert property (POWERDOWN_ACK |-> HOST_ACCESS_ACK_N)
    else $error("host ack in powerdown");
endmodule
bind pdpsc_ctrl pdpsc_chk pdpsc_chk_i (.*);
`default_nettype wire

//--- tb/pdpsc_peer.sv
// external bus master and host port master
`default_nettype none
module pdpsc_peer (
  input wire logic       CLK,
  input wire logic       want_bus,
  input wire logic [2:0] host_cmd,
  output logic           BUS_REQUEST_N,
  output logic           HOST_PORT_SELECT_N,
  output logic           HOST_READ_STROBE_N,
  output logic           HOST_STORE_STROBE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    BUS_REQUEST_N = 1'b1;
    {HOST_PORT_SELECT_N, HOST_READ_STROBE_N, HOST_STORE_STROBE_N} = 3'h7;
  end
  // host_cmd is {select, read, store}, active high
  always @(posedge CLK) begin
    BUS_REQUEST_N <= !want_bus;
    {HOST_PORT_SELECT_N, HOST_READ_STROBE_N, HOST_STORE_STROBE_N} <= ~host_cmd;
  end
endmodule
`default_nettype wire

//--- tb/pdpsc_ctrl_tb.sv
// self-checking bench for the powerdown pin state controller
`include "pdpsc_consts.svh"
`default_nettype none
module pdpsc_ctrl_tb
  import pdpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RSTN, REG_WR, REG_RD, IRQ, POWERDOWN_REQ_N, POWERDOWN_ACK, CLOCK_INPUT_PIN, CLOCK_BUFFER_EN;
  logic OSCILLATOR_EN, CRYSTAL_OUT, PROCESSOR_CLOCK_OUT, EXTERNAL_INTERRUPT2_N, EDGE_INTERRUPT_REQ_N;
  logic LEVEL_INTERRUPT_REQ0_N, LEVEL_INTERRUPT_REQ1_N, BUS_REQUEST_N, BUS_GRANT_N, CORE_DATA_DRIVE, STROBE_OE;
  logic ADDR_OE, DATA_OE, HOST_PORT_SELECT_N, HOST_READ_STROBE_N, HOST_STORE_STROBE_N, HOST_ADDRESS_LATCH;
  logic CORE_HOST_ACK, HOST_READ_CORE, HOST_STORE_CORE, HOST_LATCH_CORE, HOST_ADDR_DATA_OE, HOST_ACCESS_ACK_N;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA;
  pdpsc_strobe_type CORE_STROBE_N, STROBE_N_O;
  logic [13:0] CORE_ADDR, ADDR_O;
  logic [23:0] CORE_DATA_OUT, CORE_DATA_IN, DATA_I, DATA_O;
  logic [15:0] CORE_HOST_RDATA, HOST_ADDR_DATA_O;
  logic [2:0] HELD_OUTPUT_BITS, host_cmd;
  logic [1:0] CORE_SCLK, CORE_TX_FRAME, CORE_RX_FRAME, CORE_TX_DATA, SERIAL_CLOCK_I, SERIAL_CLOCK_O, SERIAL_CLOCK_OE;
  logic [1:0] SERIAL_TX_FRAME_I, SERIAL_TX_FRAME_O, SERIAL_TX_FRAME_OE, SERIAL_RX_FRAME_I, SERIAL_RX_FRAME_O;
  logic [1:0] SERIAL_RX_FRAME_OE, SERIAL_RX_DATA_I, SERIAL_TX_DATA_O, SERIAL_TX_DATA_OE, SERIAL_CLOCK_CORE;
  logic [1:0] SERIAL_TX_FRAME_CORE, SERIAL_RX_FRAME_CORE, SERIAL_RX_DATA_CORE;
  logic want_bus;
  int n_errors, n_tests, cyc;
  logic [11:0] cfgs [9] = '{12'h000, 12'h03F, 12'h009, 12'h011, 12'h03E, 12'hFC0, 12'h400, 12'h3C0, 12'h800};

  pdpsc_ctrl pdpsc_ctrl_i (.*);
  pdpsc_peer pdpsc_peer_i (.*);

  initial begin
    CLK = 1'b0;
    forever #5 CLK = !CLK;
  end

  // free-running core side traffic and timeout
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    CLOCK_INPUT_PIN <= cyc[0];
    SERIAL_CLOCK_I <= cyc[2:1];
    {CORE_SCLK, CORE_TX_FRAME, CORE_RX_FRAME, CORE_TX_DATA} <= cyc[7:0];
    CORE_STROBE_N <= cyc[8:2];
    CORE_ADDR <= cyc[13:0];
    CORE_DATA_OUT <= {cyc[11:0], cyc[11:0]};
    CORE_HOST_RDATA <= cyc[15:0];
    CORE_DATA_DRIVE <= cyc[1];
    HOST_ADDRESS_LATCH <= cyc[3];
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk("read data", REG_RDATA, exp);
  endtask

  task automatic wack(input logic v);
    for (int k = 0; k < 20 && POWERDOWN_ACK !== v; k++) @(posedge CLK);
    #1;
    chk("powerdown ack", POWERDOWN_ACK, v);
  endtask

  task automatic wgrant(input logic v);
    for (int k = 0; k < 20 && BUS_GRANT_N !== v; k++) @(posedge CLK);
    #1;
  endtask

  // expected {clk oe, tfs oe, rfs oe, txd oe, gated tfs, rfs, rx data}
  function automatic logic [13:0] sp_exp(input logic [11:0] c);
    logic [1:0] g;
    g = {c[6] | c[10], c[0]};
    return {c[7], c[1], c[6] & c[8], c[0] & (c[2] | c[3]), c[6] & c[9], c[0] & c[4],
            (c[6] & c[11]) | c[10], c[0] & c[5], g, g, g};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {RSTN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, want_bus, host_cmd, cyc, n_errors, n_tests} = '0;
    {CLOCK_INPUT_PIN, CORE_SCLK, CORE_TX_FRAME, CORE_RX_FRAME, CORE_TX_DATA, CORE_STROBE_N, CORE_ADDR} = '0;
    {CORE_DATA_OUT, CORE_HOST_RDATA, CORE_DATA_DRIVE, HOST_ADDRESS_LATCH, SERIAL_CLOCK_I} = '0;
    {SERIAL_TX_FRAME_I, SERIAL_RX_FRAME_I, SERIAL_RX_DATA_I, CORE_HOST_ACK} = 7'h7F;
    {POWERDOWN_REQ_N, EXTERNAL_INTERRUPT2_N, EDGE_INTERRUPT_REQ_N} = 3'h7;
    {LEVEL_INTERRUPT_REQ0_N, LEVEL_INTERRUPT_REQ1_N, DATA_I} = {2'h3, 24'hAAAAAA};
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    rd(`PDPSC_ADDR_STATE, 32'h0);
    rd(8'hFC, 32'h0);
    chk("grant idle", BUS_GRANT_N, 1'b1);
    chk("addr out", {ADDR_OE, ADDR_O}, {1'b1, 14'(CORE_ADDR - 14'h1)});
    $display("test reset done");
    wr(`PDPSC_ADDR_INT_MASK, 32'h3F);
    wr(`PDPSC_ADDR_FLAGS, 32'h5);
    POWERDOWN_REQ_N <= 1'b0;
    wack(1'b1);
    DATA_I <= 24'h555555;
    {EXTERNAL_INTERRUPT2_N, EDGE_INTERRUPT_REQ_N, LEVEL_INTERRUPT_REQ0_N, LEVEL_INTERRUPT_REQ1_N} <= 4'h0;
    want_bus <= 1'b1;
    repeat (8) @(posedge CLK);
    {EXTERNAL_INTERRUPT2_N, EDGE_INTERRUPT_REQ_N, LEVEL_INTERRUPT_REQ0_N, LEVEL_INTERRUPT_REQ1_N} <= 4'hF;
    want_bus <= 1'b0;
    repeat (8) @(posedge CLK);
    #1;
    chk("clock out", PROCESSOR_CLOCK_OUT, 1'b1);
    chk("clock buffer", CLOCK_BUFFER_EN, 1'b0);
    chk("oscillator", OSCILLATOR_EN, 1'b1);
    chk("crystal", CRYSTAL_OUT, !CLOCK_INPUT_PIN);
    chk("strobes", {STROBE_OE, STROBE_N_O}, 8'hFF);
    chk("bus oe", {ADDR_OE, DATA_OE}, 2'h0);
    chk("data in", CORE_DATA_IN, 24'hAAAAAA);
    chk("irq", IRQ, 1'b0);
    chk("grant", BUS_GRANT_N, 1'b1);
    rd(`PDPSC_ADDR_INT_STAT, 32'h3F);
    wr(`PDPSC_ADDR_FLAGS, 32'h2);
    rd(`PDPSC_ADDR_FLAGS, 32'h5);
    chk("flags", HELD_OUTPUT_BITS, 3'h5);
    $display("test powerdown pins done");
    foreach (cfgs[k]) begin
      wr(`PDPSC_ADDR_SERIAL_PORT, {20'h0, cfgs[k]});
      repeat (6) @(posedge CLK);
      #1;
      chk("serial", {SERIAL_CLOCK_OE, SERIAL_TX_FRAME_OE, SERIAL_RX_FRAME_OE, SERIAL_TX_DATA_OE, SERIAL_TX_FRAME_CORE,
          SERIAL_RX_FRAME_CORE, SERIAL_RX_DATA_CORE}, sp_exp(cfgs[k]));
      chk("serial out", {SERIAL_TX_FRAME_O, SERIAL_RX_FRAME_O, SERIAL_TX_DATA_O},
          {CORE_TX_FRAME, CORE_RX_FRAME, CORE_TX_DATA});
    end
    $display("test serial done");
    host_cmd <= 3'h3;
    repeat (8) @(posedge CLK);
    #1;
    chk("host unselected", {HOST_READ_CORE, HOST_STORE_CORE, HOST_ADDR_DATA_OE, HOST_LATCH_CORE}, 4'h0);
    host_cmd <= 3'h6;
    repeat (8) @(posedge CLK);
    #1;
    chk("host read", {HOST_READ_CORE, HOST_STORE_CORE, HOST_ADDR_DATA_OE, HOST_ACCESS_ACK_N}, 4'hB);
    host_cmd <= 3'h5;
    repeat (8) @(posedge CLK);
    #1;
    chk("host store", {HOST_READ_CORE, HOST_STORE_CORE, HOST_ADDR_DATA_OE}, 3'h2);
    chk("host data", HOST_ADDR_DATA_O, 16'(CORE_HOST_RDATA - 16'h1));
    host_cmd <= 3'h0;
    $display("test host done");
    POWERDOWN_REQ_N <= 1'b1;
    wack(1'b0);
    chk("irq after exit", IRQ, 1'b1);
    chk("host ack run", HOST_ACCESS_ACK_N, 1'b0);
    wr(`PDPSC_ADDR_INT_STAT, 32'h3F);
    rd(`PDPSC_ADDR_INT_STAT, 32'h0);
    chk("irq cleared", IRQ, 1'b0);
    wr(`PDPSC_ADDR_CTRL, 32'h3);
    wack(1'b1);
    chk("crystal off", {OSCILLATOR_EN, CRYSTAL_OUT}, 2'h1);
    wr(`PDPSC_ADDR_CTRL, 32'h0);
    wack(1'b0);
    $display("test crystal done");
    want_bus <= 1'b1;
    wgrant(1'b0);
    chk("grant run", {BUS_GRANT_N, STROBE_OE}, 2'h0);
    POWERDOWN_REQ_N <= 1'b0;
    wack(1'b1);
    want_bus <= 1'b0;
    repeat (8) @(posedge CLK);
    #1;
    chk("grant kept", {BUS_GRANT_N, STROBE_OE}, 2'h0);
    POWERDOWN_REQ_N <= 1'b1;
    wack(1'b0);
    wgrant(1'b1);
    chk("grant released", BUS_GRANT_N, 1'b1);
    $display("test grant done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
